/* File: die_pkg.sv */
package die_pkg;
    // object dictionary indices
    localparam logic [15:0] DIE_IDX_DISABLE = 16'h2010;
    localparam logic [15:0] DIE_IDX_STATE = 16'h6000;
    localparam logic [15:0] DIE_IDX_FILTER = 16'h6003;
    localparam logic [15:0] DIE_IDX_GATE = 16'h6005;
    localparam logic [15:0] DIE_IDX_ANY = 16'h6006;
    localparam logic [15:0] DIE_IDX_RISE = 16'h6007;
    localparam logic [15:0] DIE_IDX_FALL = 16'h6008;
    // subindices
    localparam logic [7:0] DIE_SUB_COUNT = 8'h00;
    localparam logic [7:0] DIE_SUB_FIRST = 8'h01;
    // reset values
    localparam logic [7:0] DIE_RST_DISABLE = 8'h00;
    localparam logic [7:0] DIE_RST_FILTER = 8'h00;
    localparam logic DIE_RST_GATE = 1'b0;
    localparam logic [7:0] DIE_RST_ANY = 8'hFF;
    localparam logic [7:0] DIE_RST_RISE = 8'h00;
    localparam logic [7:0] DIE_RST_FALL = 8'h00;
    // default transmit message
    localparam logic [10:0] DIE_COB_BASE = 11'h180;
    localparam logic [7:0] DIE_MAP_ENTRY_BITS = 8'h08;
endpackage : die_pkg

/* File: die_group.sv */
`timescale 1ns/100ps
module die_group (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // input lines from the pins
    input wire logic [7:0] line_i,
    // configuration
    input wire logic [7:0] disable_mask_i,
    input wire logic filter_en_i,
    input wire logic [7:0] any_mask_i,
    input wire logic [7:0] rise_mask_i,
    input wire logic [7:0] fall_mask_i,
    // results
    output logic [7:0] state_o,
    output logic event_o
);
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] state;
        logic event_hit;
    } die_grp_s;

    die_grp_s s_q;
    die_grp_s s_d;
    logic [7:0] filt;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = line_i;
        s_d.sync2 = s_q.sync1;
        // mask applied only when the group filter is on
        filt = filter_en_i ? (s_q.sync2 & disable_mask_i) : s_q.sync2;
        s_d.state = filt;
        // compare with previous sample
        s_d.event_hit = |(((filt ^ s_q.state) & any_mask_i)
                        | (filt & ~s_q.state & rise_mask_i)
                        | (~filt & s_q.state & fall_mask_i));
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign state_o = s_q.state;
    assign event_o = s_q.event_hit;
endmodule : die_group

/* File: die_top.sv */
`timescale 1ns/100ps
module die_top #(
    parameter int NUM_GROUPS = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // input pins
    input wire logic [NUM_GROUPS*8-1:0] lines_i,
    // node identity, same clock domain
    input wire logic [6:0] node_id_i,
    // object access port
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0] obj_sub_i,
    input wire logic [7:0] obj_wdata_i,
    output logic obj_ack_o,
    output logic obj_err_o,
    output logic [7:0] obj_rdata_o,
    // non-volatile store commands
    input wire logic nv_save_i,
    input wire logic nv_restore_i,
    // transmit message
    output logic tx_valid_o,
    output logic [10:0] tx_cob_id_o,
    output logic [NUM_GROUPS*8-1:0] tx_data_o
);
    localparam logic [7:0] NG8 = 8'(NUM_GROUPS);

    typedef logic [NUM_GROUPS-1:0][7:0] die_bytes_t;

    typedef struct packed {
        die_bytes_t dis;
        die_bytes_t filt;
        die_bytes_t any;
        die_bytes_t rise;
        die_bytes_t fall;
        logic gate;
        die_bytes_t nv_dis;
        die_bytes_t nv_filt;
        die_bytes_t nv_any;
        die_bytes_t nv_rise;
        die_bytes_t nv_fall;
        logic ack;
        logic err;
        logic [7:0] rdata;
        logic tx_valid;
        logic [10:0] cob;
        logic [NUM_GROUPS*8-1:0] data;
    } die_top_s;

    localparam die_bytes_t DIS_RST = {NUM_GROUPS{die_pkg::DIE_RST_DISABLE}};
    localparam die_bytes_t FILT_RST = {NUM_GROUPS{die_pkg::DIE_RST_FILTER}};
    localparam die_bytes_t ANY_RST = {NUM_GROUPS{die_pkg::DIE_RST_ANY}};
    localparam die_bytes_t RISE_RST = {NUM_GROUPS{die_pkg::DIE_RST_RISE}};
    localparam die_bytes_t FALL_RST = {NUM_GROUPS{die_pkg::DIE_RST_FALL}};

    localparam die_top_s TOP_RST = '{
        dis: DIS_RST, filt: FILT_RST, any: ANY_RST, rise: RISE_RST, fall: FALL_RST,
        gate: die_pkg::DIE_RST_GATE,
        nv_dis: DIS_RST, nv_filt: FILT_RST, nv_any: ANY_RST, nv_rise: RISE_RST,
        nv_fall: FALL_RST,
        default: '0
    };

    die_top_s s_q;
    die_top_s s_d;
    die_bytes_t state;
    logic [NUM_GROUPS-1:0] grp_event;
    logic sub_ok;
    logic sub_zero;
    logic [7:0] grp;
    logic any_event;

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
            die_group u_grp (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .line_i(lines_i[g*8 +: 8]),
                .disable_mask_i(s_q.dis[g]),
                .filter_en_i(s_q.filt[g] != 8'h00),
                .any_mask_i(s_q.any[g]),
                .rise_mask_i(s_q.rise[g]),
                .fall_mask_i(s_q.fall[g]),
                .state_o(state[g]),
                .event_o(grp_event[g])
            );
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        sub_zero = (obj_sub_i == die_pkg::DIE_SUB_COUNT);
        sub_ok = (obj_sub_i >= die_pkg::DIE_SUB_FIRST) && (obj_sub_i <= NG8);
        grp = obj_sub_i - die_pkg::DIE_SUB_FIRST;
        s_d.ack = obj_wr_i | obj_rd_i;
        s_d.err = 1'b0;
        s_d.rdata = 8'h00;
        if (obj_wr_i) begin
            // unmapped or read-only target answers with err only, no input-side reaction
            if (sub_ok && obj_index_i == die_pkg::DIE_IDX_DISABLE) begin
                s_d.dis[grp] = obj_wdata_i;
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_FILTER) begin
                s_d.filt[grp] = obj_wdata_i;
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_ANY) begin
                s_d.any[grp] = obj_wdata_i;
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_RISE) begin
                s_d.rise[grp] = obj_wdata_i;
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_FALL) begin
                s_d.fall[grp] = obj_wdata_i;
            end else if (sub_zero && obj_index_i == die_pkg::DIE_IDX_GATE) begin
                s_d.gate = obj_wdata_i[0];
            end else begin
                s_d.err = 1'b1;
            end
        end else if (obj_rd_i) begin
            if (sub_zero && obj_index_i != die_pkg::DIE_IDX_GATE) begin
                s_d.rdata = NG8;
                s_d.err = !(obj_index_i == die_pkg::DIE_IDX_STATE
                    || obj_index_i == die_pkg::DIE_IDX_DISABLE
                    || obj_index_i == die_pkg::DIE_IDX_FILTER
                    || obj_index_i == die_pkg::DIE_IDX_ANY
                    || obj_index_i == die_pkg::DIE_IDX_RISE
                    || obj_index_i == die_pkg::DIE_IDX_FALL);
                if (s_d.err) begin
                    s_d.rdata = 8'h00;
                end
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_STATE) begin
                s_d.rdata = state[grp];
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_DISABLE) begin
                s_d.rdata = s_q.dis[grp];
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_FILTER) begin
                s_d.rdata = s_q.filt[grp];
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_ANY) begin
                s_d.rdata = s_q.any[grp];
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_RISE) begin
                s_d.rdata = s_q.rise[grp];
            end else if (sub_ok && obj_index_i == die_pkg::DIE_IDX_FALL) begin
                s_d.rdata = s_q.fall[grp];
            end else if (sub_zero && obj_index_i == die_pkg::DIE_IDX_GATE) begin
                s_d.rdata = {7'h00, s_q.gate};
            end else begin
                s_d.err = 1'b1;
            end
        end
        // save beats restore; restore overrides a same-cycle write to any mask, but not one to the gate
        if (nv_save_i) begin
            s_d.nv_dis = s_q.dis;
            s_d.nv_filt = s_q.filt;
            s_d.nv_any = s_q.any;
            s_d.nv_rise = s_q.rise;
            s_d.nv_fall = s_q.fall;
        end else if (nv_restore_i) begin
            // gate stays as is, it is never stored
            s_d.dis = s_q.nv_dis;
            s_d.filt = s_q.nv_filt;
            s_d.any = s_q.nv_any;
            s_d.rise = s_q.nv_rise;
            s_d.fall = s_q.nv_fall;
        end
        // overlapping trigger masks are tolerated, any one hit fires once
        any_event = s_q.gate & (|grp_event);
        s_d.tx_valid = any_event;
        s_d.cob = die_pkg::DIE_COB_BASE + {4'h0, node_id_i};
        if (any_event) begin
            s_d.data = state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign obj_ack_o = s_q.ack;
    assign obj_err_o = s_q.err;
    assign obj_rdata_o = s_q.rdata;
    assign tx_valid_o = s_q.tx_valid;
    assign tx_cob_id_o = s_q.cob;
    assign tx_data_o = s_q.data;
endmodule : die_top

/* File: die_top_asserts.sv */
`timescale 1ns/100ps
module die_top_asserts #(
    parameter int NUM_GROUPS = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // watched ports
    input wire logic [6:0] node_id_i,
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0] obj_sub_i,
    input wire logic obj_ack_o,
    input wire logic obj_err_o,
    input wire logic [7:0] obj_rdata_o,
    input wire logic tx_valid_o,
    input wire logic [10:0] tx_cob_id_o,
    input wire logic [NUM_GROUPS*8-1:0] tx_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_req; obj_wr_i || obj_rd_i; endsequence
    sequence s_ans; obj_ack_o; endsequence
    a_ack_follows: assert property (s_req |=> s_ans)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (s_ans |-> $past(obj_wr_i || obj_rd_i))
        else $error("answer without request");
    a_err_ack: assert property (obj_err_o |-> obj_ack_o)
        else $error("error without answer");
    a_ro_refused: assert property (obj_wr_i && (obj_index_i == die_pkg::DIE_IDX_STATE
        || (obj_sub_i == 8'h00 && obj_index_i != die_pkg::DIE_IDX_GATE)) |=> obj_err_o)
        else $error("read-only write accepted");
    a_sub_range: assert property ((obj_wr_i || obj_rd_i) && obj_sub_i > NUM_GROUPS
        |=> obj_err_o)
        else $error("subindex out of range accepted");
    a_cob_id: assert property ($past(rst_b_i) |->
        tx_cob_id_o == die_pkg::DIE_COB_BASE + 11'($past(node_id_i)))
        else $error("message identifier wrong");
    a_tx_hold: assert property (!tx_valid_o |-> $stable(tx_data_o))
        else $error("message data moved without send");
    a_rdata_idle: assert property (!obj_ack_o || obj_err_o || $past(obj_wr_i)
        |-> obj_rdata_o == 8'h00)
        else $error("read data not zero");
endmodule : die_top_asserts
bind die_top die_top_asserts #(.NUM_GROUPS(NUM_GROUPS)) i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .node_id_i(node_id_i), .obj_wr_i(obj_wr_i), .obj_rd_i(obj_rd_i), .obj_index_i(obj_index_i),
    .obj_sub_i(obj_sub_i), .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o),
    .obj_rdata_o(obj_rdata_o), .tx_valid_o(tx_valid_o), .tx_cob_id_o(tx_cob_id_o),
    .tx_data_o(tx_data_o));

/* File: die_master_model.sv */
`timescale 1ns/100ps
module die_master_model (
    // clock
    input wire logic clk_i,
    // object port
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] idx_o,
    output logic [7:0] sub_o,
    output logic [7:0] dat_o
);
    initial {wr_o, rd_o, idx_o, sub_o, dat_o} = '0;
    // one-cycle request; index and data inverted after, subindex kept, so stale values never look valid
    task automatic put(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        idx_o <= i;
        sub_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        idx_o <= ~i;
        dat_o <= ~d;
    endtask : put
endmodule : die_master_model

/* File: digital_input_event_block_bench.sv */
`timescale 1ns/100ps
module digital_input_event_block_bench;
    logic clk_i = 1'b0, rst_b_i = 1'b0, nv_save_i = 1'b0, nv_restore_i = 1'b0;
    logic [23:0] lines_i = '0, v;
    logic wr, rd, ack, err, txv;
    logic [15:0] idx;
    logic [7:0] sub, dat, rdat;
    logic [23:0] txd;
    logic [8:0] qo [$];
    logic [23:0] qt [$];
    int fails = 0, comparisons = 0, cycles = 0, seed = 25;
    logic [15:0] ix [5] = '{die_pkg::DIE_IDX_DISABLE, die_pkg::DIE_IDX_FILTER,
        die_pkg::DIE_IDX_ANY, die_pkg::DIE_IDX_RISE, die_pkg::DIE_IDX_FALL};
    logic [7:0] rv [5] = '{die_pkg::DIE_RST_DISABLE, die_pkg::DIE_RST_FILTER,
        die_pkg::DIE_RST_ANY, die_pkg::DIE_RST_RISE, die_pkg::DIE_RST_FALL};
    always #2.5 clk_i = ~clk_i;
    die_master_model i_master (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .idx_o(idx), .sub_o(sub),
        .dat_o(dat));
    die_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .lines_i(lines_i), .node_id_i(7'h2A),
        .obj_wr_i(wr), .obj_rd_i(rd), .obj_index_i(idx), .obj_sub_i(sub), .obj_wdata_i(dat),
        .obj_ack_o(ack), .obj_err_o(err), .obj_rdata_o(rdat), .nv_save_i(nv_save_i),
        .nv_restore_i(nv_restore_i), .tx_valid_o(txv), .tx_cob_id_o(), .tx_data_o(txd));
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [7:0] d, input logic [8:0] e);
        qo.push_back(e);
        i_master.put(w, i, s, d);
    endtask : acc
    task automatic pins(input logic [23:0] p, input logic ev);
        @(posedge clk_i);
        if (ev) qt.push_back(p);
        lines_i <= p;
        repeat (8) @(posedge clk_i);
    endtask : pins
    task automatic done(input string n);
        repeat (4) @(posedge clk_i);
        $display("test %s done", n);
    endtask : done
    // an answer or a message with nothing noted takes the unknown note and fails
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            results();
        end
        if (ack === 1'b1) chk("obj", qo.size() ? qo.pop_front() : 'x, {err, rdat});
        if (txv === 1'b1) chk("tx", qt.size() ? qt.pop_front() : 'x, txd);
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        foreach (ix[k]) acc(0, ix[k], 8'h03, 8'h00, {1'b0, rv[k]});
        acc(0, die_pkg::DIE_IDX_ANY, 8'h00, 8'h00, 9'h003);
        acc(0, die_pkg::DIE_IDX_GATE, 8'h00, 8'h00, 9'h000);
        acc(1, die_pkg::DIE_IDX_STATE, 8'h01, 8'h55, 9'h100);
        acc(1, die_pkg::DIE_IDX_ANY, 8'h04, 8'h00, 9'h100);
        acc(0, 16'h1234, 8'h01, 8'h00, 9'h100);
        done("reset");
        pins(24'hA5A5A5, 1'b0);
        acc(1, die_pkg::DIE_IDX_GATE, 8'h00, 8'h01, 9'h000);
        repeat (4) begin
            v = 24'($random(seed));
            v[0] = ~lines_i[0];
            pins(v, 1'b1);
        end
        done("any");
        // one trigger type per line only
        for (int g = 1; g <= 3; g++) acc(1, die_pkg::DIE_IDX_ANY, 8'(g), 8'h00, 9'h000);
        acc(1, die_pkg::DIE_IDX_RISE, 8'h01, 8'h01, 9'h000);
        acc(1, die_pkg::DIE_IDX_FALL, 8'h02, 8'h80, 9'h000);
        v[0] = 1'b0;
        v[15] = 1'b1;
        pins(v, 1'b0);
        v[0] = 1'b1;
        pins(v, 1'b1);
        v[15] = 1'b0;
        pins(v, 1'b1);
        v[0] = 1'b0;
        v[15] = 1'b1;
        pins(v, 1'b0);
        done("edges");
        acc(1, die_pkg::DIE_IDX_DISABLE, 8'h01, 8'h0F, 9'h000);
        acc(1, die_pkg::DIE_IDX_FILTER, 8'h01, 8'h01, 9'h000);
        acc(0, die_pkg::DIE_IDX_STATE, 8'h01, 8'h00, {1'b0, v[7:0] & 8'h0F});
        acc(0, die_pkg::DIE_IDX_STATE, 8'h02, 8'h00, {1'b0, v[15:8]});
        acc(1, die_pkg::DIE_IDX_GATE, 8'h00, 8'h00, 9'h000);
        v[0] = 1'b1;
        pins(v, 1'b0);
        done("filter");
        @(posedge clk_i);
        nv_save_i <= 1'b1;
        @(posedge clk_i);
        nv_save_i <= 1'b0;
        acc(1, die_pkg::DIE_IDX_RISE, 8'h01, 8'h00, 9'h000);
        @(posedge clk_i);
        nv_restore_i <= 1'b1;
        @(posedge clk_i);
        nv_restore_i <= 1'b0;
        acc(0, die_pkg::DIE_IDX_RISE, 8'h01, 8'h00, 9'h001);
        acc(0, die_pkg::DIE_IDX_GATE, 8'h00, 8'h00, 9'h000);
        done("store");
        chk("left", 24'h0, 24'(qo.size() + qt.size()));
        results();
    end
endmodule : digital_input_event_block_bench
